/* design/pcd_port_override.sv */
// Alternate-function override and pin resolution for ports C and D.
`timescale 1ns/10ps
`default_nettype none
module pcd_port_override #(
  parameter int FILT_CYC = pcd_pkg::TW_STABLE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,

  // Global controls
  input wire logic global_pullup_disable_i,
  input wire logic compat_mode_i,
  input wire logic port_in_buf_en_i,

  // Third port registers (no pin inputs)
  input wire logic [pcd_pkg::PORT_W-1:0] pc_out_bit_i,
  input wire logic [pcd_pkg::PORT_W-1:0] pc_dir_bit_i,

  // Fourth port registers and pins
  input wire logic [pcd_pkg::PORT_W-1:0] pd_out_bit_i,
  input wire logic [pcd_pkg::PORT_W-1:0] pd_dir_bit_i,
  input wire logic [pcd_pkg::PORT_W-1:0] pd_pin_i,

  // External memory interface
  input wire logic ext_mem_enable_i,
  input wire logic [pcd_pkg::MASK_W-1:0] ext_addr_mask_i,
  input wire logic [pcd_pkg::PORT_W-1:0] ext_addr_hi_i,

  // Second serial unit
  input wire logic serial1_sync_select_i,
  input wire logic serial1_clk_gen_i,
  input wire logic serial1_tx_enable_i,
  input wire logic serial1_tx_data_i,
  input wire logic serial1_rx_enable_i,

  // Two-wire interface
  input wire logic two_wire_enable_i,
  input wire logic two_wire_sda_drive_i,
  input wire logic two_wire_scl_drive_i,

  // External interrupt enables, bit n for input n
  input wire logic [pcd_pkg::IRQ_N-1:0] ext_irq_enable_i,

  // Resolved third port pin controls
  output logic [pcd_pkg::PORT_W-1:0] pc_pullup_o,
  output logic [pcd_pkg::PORT_W-1:0] pc_dir_o,
  output logic [pcd_pkg::PORT_W-1:0] pc_out_o,
  output logic [pcd_pkg::PORT_W-1:0] pc_in_buf_en_o,

  // Resolved fourth port pin controls
  output logic [pcd_pkg::PORT_W-1:0] pd_pullup_o,
  output logic [pcd_pkg::PORT_W-1:0] pd_dir_o,
  output logic [pcd_pkg::PORT_W-1:0] pd_out_o,
  output logic [pcd_pkg::PORT_W-1:0] pd_in_buf_en_o,
  output logic [1:0] pd_slew_limit_o,

  // Pin inputs routed to peripherals
  output logic counter_one_clk_in_o,
  output logic counter_two_clk_in_o,
  output logic capture_one_input_o,
  output logic serial1_ext_clock_o,
  output logic serial1_rx_pin_o,
  output logic [pcd_pkg::IRQ_N-1:0] ext_irq_o,
  output logic two_wire_sda_in_o,
  output logic two_wire_scl_in_o
);
  import pcd_pkg::*;

  // Override enables and values, third port
  logic [PORT_W-1:0] pc_pullup_override_en;
  logic [PORT_W-1:0] pc_pullup_override_val;
  logic [PORT_W-1:0] pc_dir_override_en;
  logic [PORT_W-1:0] pc_dir_override_val;
  logic [PORT_W-1:0] pc_out_override_en;
  logic [PORT_W-1:0] pc_out_override_val;
  logic [PORT_W-1:0] pc_in_buf_override_en;
  logic [PORT_W-1:0] pc_in_buf_override_val;

  // Override enables and values, fourth port
  logic [PORT_W-1:0] pd_pullup_override_en;
  logic [PORT_W-1:0] pd_pullup_override_val;
  logic [PORT_W-1:0] pd_dir_override_en;
  logic [PORT_W-1:0] pd_dir_override_val;
  logic [PORT_W-1:0] pd_out_override_en;
  logic [PORT_W-1:0] pd_out_override_val;
  logic [PORT_W-1:0] pd_in_buf_override_en;
  logic [PORT_W-1:0] pd_in_buf_override_val;

  // Next values of the resolved pin controls
  logic [PORT_W-1:0] pc_pullup_nxt;
  logic [PORT_W-1:0] pc_dir_nxt;
  logic [PORT_W-1:0] pc_out_nxt;
  logic [PORT_W-1:0] pc_in_buf_nxt;
  logic [PORT_W-1:0] pd_pullup_nxt;
  logic [PORT_W-1:0] pd_dir_nxt;
  logic [PORT_W-1:0] pd_out_nxt;
  logic [PORT_W-1:0] pd_in_buf_nxt;

  // Effective mask and qualified enables
  logic [MASK_W-1:0] eff_mask;
  logic serial_ok;
  logic tw_active;
  logic xck_active;
  logic tx_active;
  logic rx_active;
  logic [PORT_W-1:0] addr_pin_active;

  // Filtered bus lines
  logic sda_filt;
  logic scl_filt;

  // Compatibility mode hides the mask and the newer peripherals
  always_comb begin
    eff_mask = compat_mode_i ? COMPAT_MASK : ext_addr_mask_i;
    serial_ok = !compat_mode_i;
    tw_active = two_wire_enable_i && serial_ok;
    xck_active = serial1_sync_select_i && serial_ok;
    tx_active = serial1_tx_enable_i && serial_ok;
    rx_active = serial1_rx_enable_i && serial_ok;
  end

  // Third port: each pin is claimed while the mask stays below its limit
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      // Upper nibble uses limits 1..4, lower nibble 5,6,7,7
      addr_pin_active[i] = ext_mem_enable_i && (eff_mask < ADDR_MASK_LIM[i]);
    end
    // Claimed pins are outputs with the address bit, pull-up off
    pc_pullup_override_en = addr_pin_active;
    pc_pullup_override_val = '0;
    pc_dir_override_en = addr_pin_active;
    pc_dir_override_val = '1;
    pc_out_override_en = addr_pin_active;
    pc_out_override_val = ext_addr_hi_i;
    pc_in_buf_override_en = '0;
    pc_in_buf_override_val = '0;
    // Output-only port in compatibility mode
    if (compat_mode_i) begin
      pc_dir_override_en = '1;
    end
  end

  // Fourth port override table
  always_comb begin
    // Defaults: no override on any pin
    pd_pullup_override_en = '0;
    pd_pullup_override_val = '0;
    pd_dir_override_en = '0;
    pd_dir_override_val = '0;
    pd_out_override_en = '0;
    pd_out_override_val = '0;
    pd_in_buf_override_en = '0;
    pd_in_buf_override_val = '0;

    // Counter and capture pins keep every default

    // Serial clock: value only, direction stays with the port bit
    pd_out_override_en[PD_XCK] = xck_active;
    pd_out_override_val[PD_XCK] = serial1_clk_gen_i;

    // Transmit pin: output carrying transmit data, pull-up off
    pd_pullup_override_en[PD_TX] = tx_active;
    pd_pullup_override_val[PD_TX] = 1'b0;
    pd_dir_override_en[PD_TX] = tx_active;
    pd_dir_override_val[PD_TX] = 1'b1;
    pd_out_override_en[PD_TX] = tx_active;
    pd_out_override_val[PD_TX] = serial1_tx_data_i;

    // Receive pin: input, pull-up still from the port bit
    pd_pullup_override_en[PD_RX] = rx_active;
    pd_pullup_override_val[PD_RX] = pd_out_bit_i[PD_RX] && !global_pullup_disable_i;
    pd_dir_override_en[PD_RX] = rx_active;
    pd_dir_override_val[PD_RX] = 1'b0;

    // Data line: open drain, low whenever the interface drives
    pd_pullup_override_en[PD_SDA] = tw_active;
    pd_pullup_override_val[PD_SDA] = pd_out_bit_i[PD_SDA] && !global_pullup_disable_i;
    pd_dir_override_en[PD_SDA] = tw_active;
    pd_dir_override_val[PD_SDA] = two_wire_sda_drive_i;
    pd_out_override_en[PD_SDA] = tw_active;
    pd_out_override_val[PD_SDA] = 1'b0;

    // Clock line: same open-drain scheme
    pd_pullup_override_en[PD_SCL] = tw_active;
    pd_pullup_override_val[PD_SCL] = pd_out_bit_i[PD_SCL] && !global_pullup_disable_i;
    pd_dir_override_en[PD_SCL] = tw_active;
    pd_dir_override_val[PD_SCL] = two_wire_scl_drive_i;
    pd_out_override_en[PD_SCL] = tw_active;
    pd_out_override_val[PD_SCL] = 1'b0;

    // Enabled interrupts keep their input buffer on, even in sleep
    pd_in_buf_override_en[IRQ_N-1:0] = ext_irq_enable_i;
    pd_in_buf_override_val[IRQ_N-1:0] = '1;
  end

  // Per-pin resolution of override against port registers
  for (genvar g = 0; g < PORT_W; g++) begin : g_pin
    // Ordinary pull-up: input pin with port bit set, not disabled
    logic pc_pullup_plain;
    logic pd_pullup_plain;
    assign pc_pullup_plain = pc_out_bit_i[g] && !pc_dir_bit_i[g] && !global_pullup_disable_i;
    assign pd_pullup_plain = pd_out_bit_i[g] && !pd_dir_bit_i[g] && !global_pullup_disable_i;

    // Set enable wins, otherwise the register value stands
    assign pc_pullup_nxt[g] = pc_pullup_override_en[g] ? pc_pullup_override_val[g] :
                              pc_pullup_plain;
    assign pc_dir_nxt[g] = pc_dir_override_en[g] ? pc_dir_override_val[g] :
                           pc_dir_bit_i[g];
    assign pc_out_nxt[g] = pc_out_override_en[g] ? pc_out_override_val[g] :
                           pc_out_bit_i[g];
    assign pc_in_buf_nxt[g] = pc_in_buf_override_en[g] ? pc_in_buf_override_val[g] :
                              port_in_buf_en_i;
    assign pd_pullup_nxt[g] = pd_pullup_override_en[g] ? pd_pullup_override_val[g] :
                              pd_pullup_plain;
    assign pd_dir_nxt[g] = pd_dir_override_en[g] ? pd_dir_override_val[g] :
                           pd_dir_bit_i[g];
    assign pd_out_nxt[g] = pd_out_override_en[g] ? pd_out_override_val[g] :
                           pd_out_bit_i[g];
    assign pd_in_buf_nxt[g] = pd_in_buf_override_en[g] ? pd_in_buf_override_val[g] :
                              port_in_buf_en_i;
  end

  // Spike filters on both bus lines; they run always so that
  // a freshly enabled interface sees a settled level at once
  for (genvar f = 0; f < 2; f++) begin : g_filt
    logic filt_out;
    pcd_spike_filter #(
      .STABLE_CYC(FILT_CYC),
      .CNT_W(TW_CNT_W)
    ) u_filt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .raw_i(pd_pin_i[f]),
      .filt_o(filt_out)
    );
  end
  assign scl_filt = g_filt[PD_SCL].filt_out;
  assign sda_filt = g_filt[PD_SDA].filt_out;

  // Registered third port controls; costs one cycle of latency
  // but keeps pad drivers free of glitches from the override mux
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_pullup_o <= PIN_CTRL_RST;
      pc_dir_o <= PIN_CTRL_RST;
      pc_out_o <= PIN_CTRL_RST;
      pc_in_buf_en_o <= IN_BUF_RST;
    end else begin
      pc_pullup_o <= pc_pullup_nxt;
      pc_dir_o <= pc_dir_nxt;
      pc_out_o <= pc_out_nxt;
      pc_in_buf_en_o <= pc_in_buf_nxt;
    end
  end

  // Registered fourth port controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_pullup_o <= PIN_CTRL_RST;
      pd_dir_o <= PIN_CTRL_RST;
      pd_out_o <= PIN_CTRL_RST;
      pd_in_buf_en_o <= IN_BUF_RST;
    end else begin
      pd_pullup_o <= pd_pullup_nxt;
      pd_dir_o <= pd_dir_nxt;
      pd_out_o <= pd_out_nxt;
      pd_in_buf_en_o <= pd_in_buf_nxt;
    end
  end

  // Slew limiting on both bus pins while the interface owns them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_slew_limit_o <= 2'h0;
    end else begin
      pd_slew_limit_o <= {2{tw_active}};
    end
  end

  // Pin inputs routed to the peripherals that listen to them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_one_clk_in_o <= 1'b0;
      counter_two_clk_in_o <= 1'b0;
      capture_one_input_o <= 1'b0;
      serial1_ext_clock_o <= 1'b0;
      serial1_rx_pin_o <= 1'b0;
      ext_irq_o <= 4'h0;
    end else begin
      counter_one_clk_in_o <= pd_pin_i[PD_T1];
      counter_two_clk_in_o <= pd_pin_i[PD_T2];
      capture_one_input_o <= pd_pin_i[PD_CAP];
      serial1_ext_clock_o <= pd_pin_i[PD_XCK];
      // Receive pin feeds receiver and interrupt two alike
      serial1_rx_pin_o <= pd_pin_i[PD_RX];
      ext_irq_o <= pd_pin_i[IRQ_N-1:0];
    end
  end

  // Two-wire inputs: filtered while enabled, raw otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      two_wire_sda_in_o <= TW_FILT_RST;
      two_wire_scl_in_o <= TW_FILT_RST;
    end else if (tw_active) begin
      two_wire_sda_in_o <= sda_filt;
      two_wire_scl_in_o <= scl_filt;
    end else begin
      two_wire_sda_in_o <= pd_pin_i[PD_SDA];
      two_wire_scl_in_o <= pd_pin_i[PD_SCL];
    end
  end

endmodule : pcd_port_override
`default_nettype wire

/* design/pcd_spike_filter.sv */
// Input spike filter for one two-wire bus line.
`timescale 1ns/10ps
`default_nettype none
module pcd_spike_filter #(
  parameter int STABLE_CYC = pcd_pkg::TW_STABLE_CYC,
  parameter int CNT_W = pcd_pkg::TW_CNT_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw line in, filtered line out
  input wire logic raw_i,
  output logic filt_o
);
  import pcd_pkg::*;

  // Cycles the raw line has differed from the output
  logic [CNT_W-1:0] diff_cnt_r;
  localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(STABLE_CYC - 1);

  // Count a differing level; accept only after STABLE_CYC cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      diff_cnt_r <= '0;
    end else if (raw_i == filt_o) begin
      // Any return to the old level restarts the count
      diff_cnt_r <= '0;
    end else if (diff_cnt_r == LAST_CNT) begin
      diff_cnt_r <= '0;
    end else begin
      diff_cnt_r <= diff_cnt_r + 1'b1;
    end
  end

  // Output follows only a level that stood long enough
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_o <= TW_FILT_RST;
    end else if (raw_i != filt_o && diff_cnt_r == LAST_CNT) begin
      filt_o <= raw_i;
    end
  end

endmodule : pcd_spike_filter
`default_nettype wire

/* pkg/pcd_pkg.sv */
// Constants shared by the port C/D override logic and its spike filter.
// What this block does
// - Memory enable drives address 15..12 on upper pins.
// - Memory enable drives address 11..8 on lower pins.
// - Compatibility mode: mask zero, third port output-only.
// - Synchronous select puts serial clock on pin output; port bit keeps direction.
// - Transmit enable forces transmit pin to output data.
// - Receive enable forces input; pin feeds receiver, irq.
// - Two-wire data pin becomes open drain.
// - Two-wire clock pin becomes open drain too.
// - Two-wire inputs filtered; pulses under 50 ns dropped.
// - Two-wire enable switches on slew limiting.
// - Enabled interrupt forces its input buffer on.
// - Counter and capture pins only route inputs.
// - Compatibility mode drops serial and two-wire overrides.
package pcd_pkg;

  // Port geometry
  localparam int PORT_W = 8;
  localparam int MASK_W = 3;
  localparam int IRQ_N = 4;

  // Address mask limit per third-port pin, index = pin number
  localparam logic [PORT_W-1:0][MASK_W-1:0] ADDR_MASK_LIM =
    {3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7};
  // Mask value used while compatibility mode is on
  localparam logic [MASK_W-1:0] COMPAT_MASK = 3'h0;

  // Fourth-port pin positions
  localparam int PD_SCL = 0;
  localparam int PD_SDA = 1;
  localparam int PD_RX = 2;
  localparam int PD_TX = 3;
  localparam int PD_CAP = 4;
  localparam int PD_XCK = 5;
  localparam int PD_T1 = 6;
  localparam int PD_T2 = 7;

  // Spike filter timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TW_SPIKE_NS = 50;
  // Least accepted pulse, rounded up to whole cycles
  localparam int TW_STABLE_CYC = (TW_SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TW_CNT_W = 5;
  // Bus lines idle high, so the filter starts high
  localparam logic TW_FILT_RST = 1'b1;

  // Reset values of the registered pin controls
  localparam logic [PORT_W-1:0] PIN_CTRL_RST = 8'h00;
  localparam logic [PORT_W-1:0] IN_BUF_RST = 8'hFF;

endpackage : pcd_pkg

/* testbench/pcd_pin_partner.sv */
// Far-side pin model: peers on port D, floating lines wander.
`timescale 1ns/10ps
`default_nettype none
module pcd_pin_partner (
  // Clock
  input wire logic clk_i,
  // Device pin controls
  input wire logic [7:0] dir_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] pullup_i,
  // Peer drive
  input wire logic [7:0] drv_en_i,
  input wire logic [7:0] drv_val_i,
  // Resolved levels
  output logic [7:0] pin_o
);
  logic [7:0] tog_r = 8'h55; // Changes each cycle so no stale level lingers
  // Floating pattern
  always @(posedge clk_i) begin
    tog_r <= ~tog_r;
  end
  // Device drive wins, then peer, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_o[i] = dir_i[i] ? out_i[i] : drv_en_i[i] ? drv_val_i[i] : pullup_i[i] | tog_r[i];
    end
  end
endmodule : pcd_pin_partner
`default_nettype wire

/* testbench/pcd_port_checker.sv */
// Concurrent checks on the port C/D override block.
`timescale 1ns/10ps
`default_nettype none
module pcd_port_checker
  import pcd_pkg::*;
#(
  parameter int FILT_CYC = TW_STABLE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Controls
  input wire logic global_pullup_disable_i,
  input wire logic compat_mode_i,
  input wire logic [PORT_W-1:0] pc_out_bit_i,
  input wire logic [PORT_W-1:0] pc_dir_bit_i,
  input wire logic [PORT_W-1:0] pd_out_bit_i,
  input wire logic [PORT_W-1:0] pd_dir_bit_i,
  input wire logic [PORT_W-1:0] pd_pin_i,
  input wire logic ext_mem_enable_i,
  input wire logic [MASK_W-1:0] ext_addr_mask_i,
  input wire logic [PORT_W-1:0] ext_addr_hi_i,
  input wire logic serial1_sync_select_i,
  input wire logic serial1_clk_gen_i,
  input wire logic serial1_tx_enable_i,
  input wire logic serial1_tx_data_i,
  input wire logic serial1_rx_enable_i,
  input wire logic two_wire_enable_i,
  input wire logic two_wire_sda_drive_i,
  input wire logic two_wire_scl_drive_i,
  input wire logic [IRQ_N-1:0] ext_irq_enable_i,
  // Resolved outputs
  input wire logic [PORT_W-1:0] pc_pullup_o,
  input wire logic [PORT_W-1:0] pc_dir_o,
  input wire logic [PORT_W-1:0] pc_out_o,
  input wire logic [PORT_W-1:0] pd_pullup_o,
  input wire logic [PORT_W-1:0] pd_dir_o,
  input wire logic [PORT_W-1:0] pd_out_o,
  input wire logic [PORT_W-1:0] pd_in_buf_en_o,
  input wire logic [1:0] pd_slew_limit_o,
  input wire logic counter_one_clk_in_o,
  input wire logic capture_one_input_o,
  input wire logic serial1_rx_pin_o,
  input wire logic [IRQ_N-1:0] ext_irq_o,
  input wire logic two_wire_sda_in_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic tw_on; // Compat mode silences the bus
  assign tw_on = two_wire_enable_i && !compat_mode_i;
  // Quiet high bus data line, then a one-sample dip
  sequence s_quiet;
    (tw_on && pd_pin_i[1])[*2] ##1 (tw_on && pd_pin_i[1] && two_wire_sda_in_o);
  endsequence
  sequence s_spike;
    s_quiet ##1 (tw_on && !pd_pin_i[1]) ##1 (tw_on && pd_pin_i[1]);
  endsequence
  property p_spike; s_spike |=> two_wire_sda_in_o; endproperty
  a_spike: assert property (p_spike) else $error("spike passed");
  property p_addr_hi; ext_mem_enable_i && (compat_mode_i || ext_addr_mask_i == 3'h0) |=>
    pc_dir_o[7:4] == 4'hF && pc_out_o[7:4] == $past(ext_addr_hi_i[7:4]) && pc_pullup_o[7:4] == 4'h0;
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("high nibble");
  property p_addr_lo; ext_mem_enable_i && !compat_mode_i && ext_addr_mask_i == 3'h6 |=>
    pc_dir_o[1:0] == 2'h3 && pc_out_o[1:0] == $past(ext_addr_hi_i[1:0])
    && pc_dir_o[2] == $past(pc_dir_bit_i[2]);
  endproperty
  a_addr_lo: assert property (p_addr_lo) else $error("low nibble");
  property p_compat; compat_mode_i |=> pc_dir_o == 8'hFF; endproperty
  a_compat: assert property (p_compat) else $error("compat dir");
  property p_pass; !ext_mem_enable_i && !compat_mode_i |=> pc_dir_o == $past(pc_dir_bit_i)
    && pc_out_o == $past(pc_out_bit_i);
  endproperty
  a_pass: assert property (p_pass) else $error("port pass");
  property p_xck; serial1_sync_select_i && !compat_mode_i |=> pd_out_o[5] == $past(serial1_clk_gen_i);
  endproperty
  a_xck: assert property (p_xck) else $error("sync clock");
  property p_tx; serial1_tx_enable_i && !compat_mode_i |=> pd_dir_o[3]
    && pd_out_o[3] == $past(serial1_tx_data_i) && !pd_pullup_o[3];
  endproperty
  a_tx: assert property (p_tx) else $error("tx pin");
  property p_rx; serial1_rx_enable_i && !compat_mode_i |=> !pd_dir_o[2] && serial1_rx_pin_o == ext_irq_o[2]
    && pd_pullup_o[2] == ($past(pd_out_bit_i[2]) && !$past(global_pullup_disable_i));
  endproperty
  a_rx: assert property (p_rx) else $error("rx pin");
  property p_sda; tw_on |=> pd_dir_o[1] == $past(two_wire_sda_drive_i) && !pd_out_o[1]
    && pd_slew_limit_o == 2'h3;
  endproperty
  a_sda: assert property (p_sda) else $error("data pin");
  property p_scl; tw_on |=> pd_dir_o[0] == $past(two_wire_scl_drive_i) && !pd_out_o[0]
    && pd_pullup_o[0] == ($past(pd_out_bit_i[0]) && !$past(global_pullup_disable_i));
  endproperty
  a_scl: assert property (p_scl) else $error("clock pin");
  property p_compat_d; compat_mode_i |=> pd_slew_limit_o == 2'h0
    && pd_dir_o[3:0] == $past(pd_dir_bit_i[3:0]);
  endproperty
  a_compat_d: assert property (p_compat_d) else $error("compat port d");
  property p_irq_buf; ext_irq_enable_i != 4'h0 |=>
    (pd_in_buf_en_o[3:0] & $past(ext_irq_enable_i)) == $past(ext_irq_enable_i);
  endproperty
  a_irq_buf: assert property (p_irq_buf) else $error("irq buffer");
  property p_route; !rst_i |=> counter_one_clk_in_o == $past(pd_pin_i[6])
    && capture_one_input_o == $past(pd_pin_i[4]);
  endproperty
  a_route: assert property (p_route) else $error("input route");
endmodule : pcd_port_checker
bind pcd_port_override pcd_port_checker #(.FILT_CYC(FILT_CYC)) i_chk (.*);
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the port C/D override block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pcd_pkg::*;
  localparam int FC = 4; // Short filter keeps the run brief
  logic clk_i, rst_i, global_pullup_disable_i, compat_mode_i, port_in_buf_en_i;
  logic ext_mem_enable_i, serial1_sync_select_i, serial1_clk_gen_i, serial1_tx_enable_i;
  logic serial1_tx_data_i, serial1_rx_enable_i, two_wire_enable_i;
  logic two_wire_sda_drive_i, two_wire_scl_drive_i;
  logic [7:0] pc_out_bit_i, pc_dir_bit_i, pd_out_bit_i, pd_dir_bit_i, pd_pin_i, ext_addr_hi_i;
  logic [7:0] pc_pullup_o, pc_dir_o, pc_out_o, pc_in_buf_en_o, ext_drv_en, ext_val, pin_s;
  logic [7:0] pd_pullup_o, pd_dir_o, pd_out_o, pd_in_buf_en_o;
  logic [2:0] ext_addr_mask_i;
  logic [3:0] ext_irq_enable_i, ext_irq_o;
  logic [1:0] pd_slew_limit_o;
  logic counter_one_clk_in_o, counter_two_clk_in_o, capture_one_input_o, serial1_ext_clock_o;
  logic serial1_rx_pin_o, two_wire_sda_in_o, two_wire_scl_in_o;
  int miscompares = 0;
  int n_compared = 0;
  pcd_port_override #(.FILT_CYC(FC)) i_dut (.*);
  pcd_pin_partner i_far (.clk_i(clk_i), .dir_i(pd_dir_o), .out_i(pd_out_o),
    .pullup_i(pd_pullup_o), .drv_en_i(ext_drv_en), .drv_val_i(ext_val), .pin_o(pd_pin_i));
  // Clock, 4 ns
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Pin level as the block sampled it
  always @(posedge clk_i) pin_s <= pd_pin_i;
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : cmp
  // Expected pin controls worked out from the current inputs
  task automatic chk;
    logic [7:0] cl, d, o, p, pu, eb;
    logic tx, rx, tw, sy;
    pu = ~{8{global_pullup_disable_i}};
    tx = serial1_tx_enable_i & ~compat_mode_i;
    rx = serial1_rx_enable_i & ~compat_mode_i;
    tw = two_wire_enable_i & ~compat_mode_i;
    sy = serial1_sync_select_i & ~compat_mode_i;
    for (int i = 0; i < 8; i++) cl[i] = ext_mem_enable_i
      && ((compat_mode_i ? 3'h0 : ext_addr_mask_i) < ADDR_MASK_LIM[i]);
    d = compat_mode_i ? 8'hFF : (cl | pc_dir_bit_i);
    cmp("pc_dir", d, pc_dir_o);
    cmp("pc_out", (cl & ext_addr_hi_i) | (~cl & pc_out_bit_i), pc_out_o);
    cmp("pc_pu", pc_out_bit_i & ~(cl | pc_dir_bit_i) & pu, pc_pullup_o);
    cmp("pc_ib", {8{port_in_buf_en_i}}, pc_in_buf_en_o);
    d = pd_dir_bit_i;
    o = pd_out_bit_i;
    d[3] = tx | d[3];
    o[3] = tx ? serial1_tx_data_i : o[3];
    d[2] = ~rx & d[2];
    d[1] = tw ? two_wire_sda_drive_i : d[1];
    d[0] = tw ? two_wire_scl_drive_i : d[0];
    o[1:0] = tw ? 2'h0 : o[1:0];
    o[5] = sy ? serial1_clk_gen_i : o[5];
    p = pd_out_bit_i & ~d & pu;
    p[1:0] = tw ? pd_out_bit_i[1:0] & pu[1:0] : p[1:0];
    eb = {8{port_in_buf_en_i}};
    eb[3:0] = eb[3:0] | ext_irq_enable_i;
    cmp("pd_dir", d, pd_dir_o);
    cmp("pd_out", o, pd_out_o);
    cmp("pd_pu", p, pd_pullup_o);
    cmp("pd_ib", eb, pd_in_buf_en_o);
    cmp("slew", {6'h0, tw, tw}, {6'h0, pd_slew_limit_o});
    cmp("route", pin_s, {counter_two_clk_in_o, counter_one_clk_in_o, serial1_ext_clock_o,
      capture_one_input_o, ext_irq_o});
    cmp("rx", {7'h0, pin_s[2]}, {7'h0, serial1_rx_pin_o});
    if (!tw) cmp("tw_raw", {6'h0, pin_s[1:0]},
      {6'h0, two_wire_sda_in_o, two_wire_scl_in_o});
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1 chk();
  endtask : step
  task automatic give_verdict;
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  // Hang guard, well past the expected run
  initial begin
    repeat (3000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end
  initial begin
    {rst_i, port_in_buf_en_i} = 2'h3;
    {global_pullup_disable_i, compat_mode_i, ext_mem_enable_i, serial1_sync_select_i} = 4'h0;
    {serial1_clk_gen_i, serial1_tx_enable_i, serial1_tx_data_i, serial1_rx_enable_i} = 4'h0;
    {two_wire_enable_i, two_wire_sda_drive_i, two_wire_scl_drive_i} = 3'h0;
    {pc_out_bit_i, pc_dir_bit_i, pd_out_bit_i, pd_dir_bit_i} = 32'h0000_0000;
    {ext_addr_hi_i, ext_drv_en, ext_val} = 24'h00_0000;
    ext_addr_mask_i = 3'h0;
    ext_irq_enable_i = 4'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // Address claim over every mask value, memory on and off
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_i);
      ext_mem_enable_i <= k[3];
      ext_addr_mask_i <= k[2:0];
      ext_addr_hi_i <= k[0] ? 8'hA5 : 8'h5A;
      pc_out_bit_i <= 8'h3C;
      pc_dir_bit_i <= 8'h0F ^ {8{k[1]}};
      global_pullup_disable_i <= k[0];
      step(1);
    end
    // Serial, two-wire and interrupt overrides, normal then compat
    for (int k = 0; k < 64; k++) begin
      @(posedge clk_i);
      compat_mode_i <= k[5];
      ext_mem_enable_i <= k[5];
      ext_addr_mask_i <= 3'h7;
      pc_out_bit_i <= 8'hC3 ^ {8{k[2]}};
      port_in_buf_en_i <= k[4];
      {serial1_sync_select_i, serial1_tx_enable_i, serial1_rx_enable_i} <= k[2:0];
      serial1_tx_data_i <= k[3];
      serial1_clk_gen_i <= ~k[3];
      two_wire_enable_i <= k[4];
      {two_wire_sda_drive_i, two_wire_scl_drive_i} <= k[1:0];
      pd_dir_bit_i <= 8'h2C ^ {8{k[3]}};
      pd_out_bit_i <= 8'hA7 ^ {8{k[2]}};
      global_pullup_disable_i <= k[3];
      ext_irq_enable_i <= k[3:0];
      ext_drv_en <= 8'hF7;
      ext_val <= {k[3:0], ~k[3:0]};
      step(1);
    end
    // Spike filter: pulses up to the limit on each bus line
    @(posedge clk_i);
    {compat_mode_i, two_wire_sda_drive_i, two_wire_scl_drive_i} <= 3'h0;
    two_wire_enable_i <= 1'b1;
    {ext_drv_en, ext_val} <= 16'hFFFF;
    step(FC + 2);
    for (int b = 0; b < 2; b++) begin
      for (int w = 1; w <= FC; w++) begin
        @(posedge clk_i);
        ext_val[b] <= 1'b0;
        repeat (w) @(posedge clk_i);
        ext_val[b] <= 1'b1;
        #1 cmp("tw_in", 8'h1, {7'h0, b ? two_wire_sda_in_o : two_wire_scl_in_o});
        @(posedge clk_i);
        #1 cmp("tw_in", {7'h0, w < FC}, {7'h0, b ? two_wire_sda_in_o : two_wire_scl_in_o});
        repeat (FC + 2) @(posedge clk_i);
      end
    end
    give_verdict();
  end
endmodule : tb
`default_nettype wire
